// File: src/abm_master.v
// Purpose: Asynchronous bus master interface of a 16-bit processor
// Assumes: Core issues one request at a time; pins active low where _N
// Notes:   Data lanes and byte strobes are two signals each
//
// Functional notes
// - Drive 23-bit word address bus, tri-statable, except interrupt cycles.
// - Interrupt cycle: level on three low lines, all higher lines high.
// - 16-bit bidirectional tri-statable data path, word or single byte.
// - Address strobe asserted only while address is valid.
// - Direction high for read, low for write; with strobes selects lanes.
// - Read strobes: both word, upper high byte, lower low byte.
// - Byte write copies selected byte onto both data halves.
// - Read: on acknowledge latch data and end cycle.
// - Write: on acknowledge end cycle.
// - Assert grant to signal release at end of current cycle.
// - Byte transfer: select bit zero upper strobe, one lower strobe.
// - Cycle type code stays valid while address strobe asserted.
`timescale 1ns/1ns
`include "abm_map.vh"
module abm_master #(
    parameter ADDR_W = `ABM_ADDR_W,
    parameter DATA_W = `ABM_DATA_W
) (
    input  wire              I_CORE_CLK,
    input  wire              I_RESET,
    // Core side request
    input  wire              i_req_valid,
    output wire              o_req_ready,
    input  wire              i_req_read,
    input  wire              i_req_byte,
    input  wire              i_req_byte_select_bit,
    input  wire [ADDR_W-1:0] i_req_addr,
    input  wire [DATA_W-1:0] i_req_wdata,
    input  wire [2:0]        i_req_cycle_type_code,
    input  wire [2:0]        i_req_int_level,
    output reg               o_done,
    output reg  [DATA_W-1:0] o_rdata,
    output reg               o_bus_owned,
    // Pins
    output reg  [ADDR_W-1:0] O_ADDR,
    output wire              O_ADDR_OE,
    input  wire [DATA_W-1:0] I_DATA,
    output reg  [DATA_W-1:0] O_DATA,
    output wire              O_DATA_OE,
    output reg               O_ADDRESS_VALID_STROBE_N,
    output reg               O_UPPER_BYTE_STROBE_N,
    output reg               O_LOWER_BYTE_STROBE_N,
    output reg               O_READ_WRITE,
    output wire              O_CTRL_OE,
    output reg  [2:0]        O_CYCLE_TYPE_CODE,
    input  wire              I_TRANSFER_ACKNOWLEDGE_N,
    input  wire              I_MASTERSHIP_REQUEST_N,
    output reg               O_MASTERSHIP_GRANT_N,
    input  wire              I_MASTERSHIP_GRANT_ACK_N
);
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    wire ack_n;
    wire req_n;
    wire gack_n;

    abm_sync #(.RESET_VAL(1'b1)) u_sync_ack (
        .i_clk   (I_CORE_CLK),
        .i_reset (I_RESET),
        .i_pin   (I_TRANSFER_ACKNOWLEDGE_N),
        .o_level (ack_n)
    );
    abm_sync #(.RESET_VAL(1'b1)) u_sync_req (
        .i_clk   (I_CORE_CLK),
        .i_reset (I_RESET),
        .i_pin   (I_MASTERSHIP_REQUEST_N),
        .o_level (req_n)
    );
    abm_sync #(.RESET_VAL(1'b1)) u_sync_gack (
        .i_clk   (I_CORE_CLK),
        .i_reset (I_RESET),
        .i_pin   (I_MASTERSHIP_GRANT_ACK_N),
        .o_level (gack_n)
    );

    // ************************************************************
    // Lane and strobe decode
    // ************************************************************
    // Returns {upper_n, lower_n}; both low for a word
    function [1:0] strobes_n;
        input is_byte;
        input sel;
        begin
            if (!is_byte) begin
                strobes_n = 2'h0;
            end else if (!sel) begin
                strobes_n = 2'h1;
            end else begin
                strobes_n = 2'h2;
            end
        end
    endfunction

    // Byte writes mirror the byte onto both lanes
    function [DATA_W-1:0] write_lanes;
        input              is_byte;
        input              sel;
        input [DATA_W-1:0] d;
        begin
            if (!is_byte) begin
                write_lanes = d;
            end else if (!sel) begin
                write_lanes = {d[15:8], d[15:8]};
            end else begin
                write_lanes = {d[7:0], d[7:0]};
            end
        end
    endfunction

    // ************************************************************
    // Sequencer
    // ************************************************************
    localparam [2:0] ST_IDLE     = 3'h0;
    localparam [2:0] ST_ADDR     = 3'h1;
    localparam [2:0] ST_STROBE   = 3'h2;
    localparam [2:0] ST_END      = 3'h3;
    localparam [2:0] ST_RELEASED = 3'h4;

    reg  [2:0]        state_q;
    reg               read_q;
    reg               byte_q;
    reg               sel_q;
    reg               data_oe_q;
    reg               float_q;
    wire              accept;

    // Pending bus request wins; ready low so a take is never dropped
    assign o_req_ready = (state_q == ST_IDLE) && O_MASTERSHIP_GRANT_N
                         && req_n;
    assign accept      = i_req_valid && o_req_ready;
    // Pins float while another master owns the bus
    assign O_ADDR_OE   = !float_q;
    assign O_CTRL_OE   = !float_q;
    assign O_DATA_OE   = data_oe_q && !float_q;

    always @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            state_q                  <= ST_IDLE;
            read_q                   <= 1'b1;
            byte_q                   <= 1'b0;
            sel_q                    <= 1'b0;
            data_oe_q                <= 1'b0;
            float_q                  <= 1'b0;
            O_ADDR                   <= {ADDR_W{1'b0}};
            O_DATA                   <= {DATA_W{1'b0}};
            O_ADDRESS_VALID_STROBE_N <= 1'b1;
            O_UPPER_BYTE_STROBE_N    <= 1'b1;
            O_LOWER_BYTE_STROBE_N    <= 1'b1;
            O_READ_WRITE             <= 1'b1;
            O_CYCLE_TYPE_CODE        <= 3'h0;
            O_MASTERSHIP_GRANT_N     <= 1'b1;
            o_done                   <= 1'b0;
            o_rdata                  <= {DATA_W{1'b0}};
            o_bus_owned              <= 1'b1;
        end else begin
            o_done <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (!req_n) begin
                        O_MASTERSHIP_GRANT_N <= 1'b0;
                        state_q              <= ST_RELEASED;
                    end else if (accept) begin
                        read_q <= i_req_read;
                        byte_q <= i_req_byte;
                        sel_q  <= i_req_byte_select_bit;
                        if (i_req_cycle_type_code == `ABM_FC_INT_ACK) begin
                            O_ADDR <= {{(ADDR_W-3){1'b1}},
                                       i_req_int_level};
                        end else begin
                            O_ADDR <= i_req_addr;
                        end
                        O_CYCLE_TYPE_CODE <= i_req_cycle_type_code;
                        O_READ_WRITE      <= i_req_read;
                        O_DATA <= write_lanes(i_req_byte,
                                              i_req_byte_select_bit,
                                              i_req_wdata);
                        data_oe_q <= !i_req_read;
                        state_q   <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    // Address settled one cycle before the strobe
                    O_ADDRESS_VALID_STROBE_N <= 1'b0;
                    {O_UPPER_BYTE_STROBE_N, O_LOWER_BYTE_STROBE_N} <=
                        strobes_n(byte_q, sel_q);
                    state_q <= ST_STROBE;
                end
                ST_STROBE: begin
                    if (!ack_n) begin
                        if (read_q) begin
                            o_rdata <= I_DATA;
                        end
                        O_ADDRESS_VALID_STROBE_N <= 1'b1;
                        O_UPPER_BYTE_STROBE_N    <= 1'b1;
                        O_LOWER_BYTE_STROBE_N    <= 1'b1;
                        state_q                  <= ST_END;
                    end
                end
                ST_END: begin
                    // Wait for the responder to drop its acknowledge
                    data_oe_q <= 1'b0;
                    if (ack_n) begin
                        o_done       <= 1'b1;
                        O_READ_WRITE <= 1'b1;
                        state_q      <= ST_IDLE;
                    end
                end
                ST_RELEASED: begin
                    if (!gack_n) begin
                        float_q              <= 1'b1;
                        o_bus_owned          <= 1'b0;
                        O_MASTERSHIP_GRANT_N <= 1'b1;
                    end else if (float_q || req_n) begin
                        // Owner left, or requester withdrew
                        float_q              <= 1'b0;
                        o_bus_owned          <= 1'b1;
                        O_MASTERSHIP_GRANT_N <= 1'b1;
                        state_q              <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// File: src/abm_map.vh
// Purpose: Constants for the asynchronous bus master interface
// Assumes: Plain Verilog-2005, included by bare name
// Notes:   Pin levels are active low where named _n
`ifndef ABM_MAP_VH
`define ABM_MAP_VH

// ************************************************************
// Widths
// ************************************************************
`define ABM_ADDR_W        23
`define ABM_DATA_W        16
`define ABM_FC_W          3
`define ABM_LVL_W         3

// ************************************************************
// Cycle type codes
// ************************************************************
`define ABM_FC_USER_DATA  3'h1
`define ABM_FC_USER_PROG  3'h2
`define ABM_FC_SUP_DATA   3'h5
`define ABM_FC_SUP_PROG   3'h6
`define ABM_FC_INT_ACK    3'h7

// ************************************************************
// Timing
// ************************************************************
`define ABM_SYNC_STAGES   3

`endif

// File: src/abm_sync.v
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to i_clk
// Notes:   Output changes once stages two and three agree
`timescale 1ns/1ns
module abm_sync #(
    parameter RESET_VAL = 1'b1
) (
    input  wire i_clk,
    input  wire i_reset,
    input  wire i_pin,
    output reg  o_level
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s1_q    <= RESET_VAL;
            s2_q    <= RESET_VAL;
            s3_q    <= RESET_VAL;
            o_level <= RESET_VAL;
        end else begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                o_level <= s3_q;
            end
        end
    end
endmodule

// File: tb/abm_master_props.sv
// Purpose: Pin-level properties of the bus master
// Assumes: Bound to abm_master; pins active low where _N
// Notes:   Bounds allow for the three-stage input synchroniser
`timescale 1ns/1ns
module abm_master_props #(
    parameter ADDR_W = 23,
    parameter DATA_W = 16
) (
    input wire              I_CORE_CLK,
    input wire              I_RESET,
    input wire [ADDR_W-1:0] O_ADDR,
    input wire              O_ADDR_OE,
    input wire [DATA_W-1:0] O_DATA,
    input wire              O_DATA_OE,
    input wire              O_ADDRESS_VALID_STROBE_N,
    input wire              O_UPPER_BYTE_STROBE_N,
    input wire              O_LOWER_BYTE_STROBE_N,
    input wire              O_READ_WRITE,
    input wire              O_CTRL_OE,
    input wire [2:0]        O_CYCLE_TYPE_CODE,
    input wire              I_TRANSFER_ACKNOWLEDGE_N,
    input wire              O_MASTERSHIP_GRANT_N,
    input wire              I_MASTERSHIP_GRANT_ACK_N
);
    wire as_n = O_ADDRESS_VALID_STROBE_N;
    wire ds_n = O_UPPER_BYTE_STROBE_N & O_LOWER_BYTE_STROBE_N;
    wire rw   = O_READ_WRITE;
    wire bsel = O_UPPER_BYTE_STROBE_N ^ O_LOWER_BYTE_STROBE_N;
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RESET);
    // ****
    // Properties
    // ****
    sequence s_ack;
        !as_n && !I_TRANSFER_ACKNOWLEDGE_N;
    endsequence
    sequence s_end;
        ##[1:10] (as_n && ds_n);
    endsequence
    property p_rd_end;
        s_ack ##0 rw |-> s_end;
    endproperty
    property p_wr_end;
        s_ack ##0 !rw |-> s_end;
    endproperty
    property p_drive;
        !as_n |-> O_ADDR_OE && O_CTRL_OE;
    endproperty
    property p_addr;
        !as_n [*2] |-> $stable(O_ADDR);
    endproperty
    property p_code;
        !as_n [*2] |-> $stable(O_CYCLE_TYPE_CODE);
    endproperty
    property p_int;
        !as_n && O_CYCLE_TYPE_CODE == 3'h7 |-> &O_ADDR[ADDR_W-1:3];
    endproperty
    property p_mirror;
        !as_n && !rw && bsel |-> O_DATA[15:8] == O_DATA[7:0];
    endproperty
    property p_dir;
        O_DATA_OE |-> !rw;
    endproperty
    property p_grant;
        !O_MASTERSHIP_GRANT_N |-> as_n && ds_n;
    endproperty
    property p_float;
        $fell(I_MASTERSHIP_GRANT_ACK_N) ##0 !O_MASTERSHIP_GRANT_N
            |-> ##[1:8] !(O_ADDR_OE | O_DATA_OE | O_CTRL_OE);
    endproperty
    a_rd_end: assert property (p_rd_end) else $error("read not ended");
    a_wr_end: assert property (p_wr_end) else $error("write hung");
    a_drive: assert property (p_drive) else $error("pins floating");
    a_addr: assert property (p_addr) else $error("address moved");
    a_code: assert property (p_code) else $error("code moved");
    a_int: assert property (p_int) else $error("int address");
    a_mirror: assert property (p_mirror) else $error("no mirror");
    a_dir: assert property (p_dir) else $error("data on read");
    a_grant: assert property (p_grant) else $error("grant in cycle");
    a_float: assert property (p_float) else $error("not floated");
endmodule
bind abm_master abm_master_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
    u_abm_master_props (.*);

// File: tb/abm_slave.sv
// Purpose: Memory and vector responder on the far side
// Assumes: Strobes already pulled high when not driven
// Notes:   Idle data lanes toggle so stale values never pass
`timescale 1ns/1ns
module abm_slave (
    input  wire        i_clk,
    input  wire        i_as_n,
    input  wire        i_uds_n,
    input  wire        i_lds_n,
    input  wire        i_rw,
    input  wire [22:0] i_addr,
    input  wire [15:0] i_wdata,
    input  wire [7:0]  i_wait,
    output reg  [15:0] o_rdata,
    output reg         o_ack_n
);
    reg [15:0] mem [0:15];
    reg [7:0]  cnt_q;
    wire [3:0] a = i_addr[3:0];
    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
        cnt_q = 8'h00;
        o_rdata = 16'h0000;
        o_ack_n = 1'b1;
    end
    // ****
    // Responder
    // ****
    always @(posedge i_clk) begin
        if (i_as_n || (i_uds_n && i_lds_n)) begin
            cnt_q <= 8'h00;
            o_ack_n <= 1'b1;
            o_rdata <= ~o_rdata;
        end else if (cnt_q < i_wait) begin
            cnt_q <= cnt_q + 8'h01;
            o_rdata <= ~o_rdata;
        end else begin
            o_ack_n <= 1'b0;
            if (!i_rw && !i_uds_n) mem[a][15:8] <= i_wdata[15:8];
            if (!i_rw && !i_lds_n) mem[a][7:0] <= i_wdata[7:0];
            if (i_rw) o_rdata <= &i_addr[22:3] ?
                {~o_rdata[15:8], 5'h08, i_addr[2:0]} : mem[a];
        end
    end
endmodule

// File: tb/abm_master_tb.sv
// Purpose: Self-checking bench for the bus master
// Assumes: Responder model answers after i_wait cycles
// Notes:   Other master is played by the bench itself
`timescale 1ns/1ns
module abm_master_tb;
    logic        I_CORE_CLK, I_RESET, i_req_valid, i_req_read, i_req_byte;
    logic        i_req_byte_select_bit, I_TRANSFER_ACKNOWLEDGE_N;
    logic        I_MASTERSHIP_REQUEST_N, I_MASTERSHIP_GRANT_ACK_N;
    logic        o_req_ready, o_done, o_bus_owned, O_ADDR_OE, O_DATA_OE;
    logic        O_ADDRESS_VALID_STROBE_N, O_UPPER_BYTE_STROBE_N;
    logic        O_LOWER_BYTE_STROBE_N, O_READ_WRITE, O_CTRL_OE;
    logic        O_MASTERSHIP_GRANT_N, c_oe;
    logic [2:0]  i_req_cycle_type_code, i_req_int_level, O_CYCLE_TYPE_CODE;
    logic [2:0]  seen_cc;
    logic [22:0] i_req_addr, O_ADDR;
    logic [15:0] i_req_wdata, o_rdata, I_DATA, O_DATA, sl_data, rd;
    logic [7:0]  wait_cyc;
    int          error_cnt, check_count, cyc;
    assign I_DATA = O_DATA_OE ? O_DATA : sl_data;
    assign c_oe = O_CTRL_OE;
    abm_master u_abm_master (.*);
    abm_slave u_abm_slave (.i_clk(I_CORE_CLK), .i_rw(O_READ_WRITE),
        .i_as_n(O_ADDRESS_VALID_STROBE_N | ~c_oe), .i_addr(O_ADDR),
        .i_uds_n(O_UPPER_BYTE_STROBE_N | ~c_oe), .i_wdata(O_DATA),
        .i_lds_n(O_LOWER_BYTE_STROBE_N | ~c_oe), .i_wait(wait_cyc),
        .o_rdata(sl_data), .o_ack_n(I_TRANSFER_ACKNOWLEDGE_N));
    always #2 I_CORE_CLK = ~I_CORE_CLK;
    always @(negedge O_ADDRESS_VALID_STROBE_N) seen_cc = O_CYCLE_TYPE_CODE;
    always @(posedge I_CORE_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test;
        end
    end
    // ****
    // Tasks
    // ****
    task chk(input logic [15:0] seen, input logic [15:0] exp, string nm);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task xfer(input logic r, b, s, input logic [22:0] a,
              input logic [15:0] wd, input logic [2:0] cc);
        int n;
        {i_req_read, i_req_byte, i_req_byte_select_bit} = {r, b, s};
        {i_req_addr, i_req_wdata, i_req_cycle_type_code} = {a, wd, cc};
        i_req_int_level = a[2:0];
        i_req_valid = 1'b1;
        for (n = 0; n < 100 && o_req_ready !== 1'b1; n++)
            @(posedge I_CORE_CLK) #1;
        @(posedge I_CORE_CLK);
        #1 i_req_valid = 1'b0;
        for (n = 0; n < 200 && o_done !== 1'b1; n++)
            @(posedge I_CORE_CLK) #1;
        chk(o_done, 1'b1, "done");
        rd = o_rdata;
    endtask
    task t_word(input logic [7:0] w);
        wait_cyc = w;
        xfer(0, 0, 0, 23'h3, 16'h1234, 3'h1);
        // Neighbour write must not alias onto the word under test
        xfer(0, 0, 0, 23'h4, 16'h5678, 3'h1);
        xfer(1, 0, 0, 23'h3, 16'h0000, 3'h5);
        chk(rd, 16'h1234, "word read");
    endtask
    task t_byte;
        xfer(0, 1, 1, 23'h3, 16'h00ab, 3'h1);
        xfer(0, 1, 0, 23'h3, 16'hcd00, 3'h1);
        xfer(1, 0, 0, 23'h3, 16'h0000, 3'h1);
        chk(rd, 16'hcdab, "byte merge");
        xfer(1, 1, 1, 23'h3, 16'h0000, 3'h2);
        chk(rd[7:0], 8'hab, "low lane");
        xfer(1, 1, 0, 23'h3, 16'h0000, 3'h2);
        chk(rd[15:8], 8'hcd, "high lane");
    endtask
    task t_codes;
        logic [2:0] c [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
        foreach (c[i]) begin
            xfer(1, 0, 0, 23'h3, 16'h0000, c[i]);
            chk(seen_cc, c[i], "cycle code");
        end
        xfer(1, 1, 1, 23'h5, 16'h0000, 3'h7);
        chk(rd[7:0], 8'h45, "vector");
    endtask
    task t_withdraw;
        I_MASTERSHIP_REQUEST_N = 1'b0;
        repeat (6) @(posedge I_CORE_CLK);
        #1 chk(O_MASTERSHIP_GRANT_N, 1'b0, "early grant");
        I_MASTERSHIP_REQUEST_N = 1'b1;
        repeat (6) @(posedge I_CORE_CLK);
        #1 chk({O_MASTERSHIP_GRANT_N, o_req_ready, o_bus_owned}, 3'h7,
               "withdrawn");
    endtask
    task t_arb;
        int n;
        I_MASTERSHIP_REQUEST_N = 1'b0;
        for (n = 0; n < 50 && O_MASTERSHIP_GRANT_N !== 1'b0; n++)
            @(posedge I_CORE_CLK) #1;
        chk(O_MASTERSHIP_GRANT_N, 1'b0, "grant");
        chk(o_req_ready, 1'b0, "ready in grant");
        {I_MASTERSHIP_GRANT_ACK_N, I_MASTERSHIP_REQUEST_N} = 2'h1;
        repeat (10) @(posedge I_CORE_CLK);
        #1 chk({O_ADDR_OE, c_oe, O_DATA_OE, o_bus_owned}, 4'h0,
               "float");
        chk(O_MASTERSHIP_GRANT_N, 1'b1, "grant off");
        I_MASTERSHIP_GRANT_ACK_N = 1'b1;
        repeat (10) @(posedge I_CORE_CLK);
        #1 chk({O_ADDR_OE, o_bus_owned}, 2'h3, "owned");
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        {I_CORE_CLK, I_RESET, i_req_valid, i_req_read} = 4'h4;
        {i_req_byte, i_req_byte_select_bit, wait_cyc} = 10'h000;
        {i_req_addr, i_req_wdata, i_req_int_level} = 42'h0;
        i_req_cycle_type_code = 3'h1;
        {I_MASTERSHIP_REQUEST_N, I_MASTERSHIP_GRANT_ACK_N} = 2'h3;
        repeat (10) @(posedge I_CORE_CLK);
        chk({O_ADDRESS_VALID_STROBE_N, O_MASTERSHIP_GRANT_N}, 2'h3,
            "rst");
        #1 I_RESET = 1'b0;
        t_word(8'h00);
        t_word(8'h14);
        t_byte;
        t_codes;
        t_withdraw;
        t_arb;
        t_word(8'h03);
        end_of_test;
    end
endmodule
